// ===== design/edge_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser with a third stage for edge finding
module edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;
endmodule // edge_sync

// ===== design/serial_chan_pkg.sv
package serial_chan_pkg;

  // register byte addresses; the bus control offset is not word aligned, so it
  // is kept as a word index and its byte address is four times that index
  localparam logic [15:0] IDX_BUS_CTRL    = 16'hff61;
  localparam logic [17:0] ADDR_BUS_CTRL   = {IDX_BUS_CTRL, 2'b00};
  localparam logic [17:0] ADDR_MODE       = 18'h00000;
  localparam logic [17:0] ADDR_SHIFT      = 18'h00004;
  localparam logic [17:0] ADDR_SLAVE_ADDR = 18'h00008;
  localparam logic [17:0] ADDR_STATUS     = 18'h0000c;

  // serial_mode_reg fields
  localparam int MODE_ENABLE_BIT = 7;
  localparam int MODE_MATCH_BIT  = 6;
  localparam int MODE_WAKE_BIT   = 5;
  localparam int MODE_HI_BIT     = 4;
  localparam int MODE_MID_BIT    = 3;
  localparam int MODE_LO_BIT     = 2;

  // bus_ctrl_reg fields
  localparam int BC_REL_TRIG_BIT = 0;
  localparam int BC_CMD_TRIG_BIT = 1;
  localparam int BC_REL_DET_BIT  = 2;
  localparam int BC_CMD_DET_BIT  = 3;

  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [7:0] BUS_CTRL_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET   = 8'hff;
  localparam logic [3:0] BIT_COUNT_LAST = 4'h8;

  typedef enum logic [1:0] {
    MODE_THREE_WIRE,
    MODE_ADDR_BUS,
    MODE_TWO_WIRE
  } chan_mode_t;

  // per-pin drive bundle: output level and enable
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

endpackage

// ===== design/serial_channel.sv
`timescale 1ns/1ns
// Operation
// RL1 - mode hi bit 0: three-wire mode; lo bit picks MSB or LSB first
// RL2 - modes 100/101: addressed bus, MSB first, lo bit picks open-drain data pin
// RL3 - modes 110/111: two-wire, MSB first, data and clock pins open-drain
// RL4 - software sets port direction and latch bits as the mode needs
// RL5 - three-wire transmit-only: serial input pin may be a plain port input
// RL6 - wake bit 0: interrupt after every completed transfer, any mode
// RL7 - wake bit 1 in bus mode: interrupt only on address match after release
// RL8 - software keeps release-interrupt select cleared when using wake-up
// RL9 - match flag is read-only, 1 when slave address equals shift register
// RL10 - match flag forced 0 while channel disabled
// RL11 - enable bit 0 stops all serial operation, 1 enables it
// RL12 - bus control resets to zero; detect flags read-only, triggers writable
// RL13 - release trigger sets latch, command trigger clears; both self-clear (command trigger is ignored while disabled)
// RL14 - release-detected flag set when bus release is seen on the bus
// RL15 - release-detected cleared by transfer start, disable or reset
// RL16 - release-detected cleared on address mismatch during address reception
// RL17 - command-detected set on command, cleared by start, release, disable, reset
// RL18 - writing shift register while enabled starts a transfer
// RL19 - software changes mode only while channel disabled
// RL20 - trigger bits read back 0 once their latch action is done
module serial_channel (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [17:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        sclk_in,
  output serial_chan_pkg::pin_drive_t      sclk_drv,
  input  wire logic                        pin_a_in,
  output serial_chan_pkg::pin_drive_t      pin_a_drv,
  input  wire logic                        pin_b_in,
  output serial_chan_pkg::pin_drive_t      pin_b_drv,
  output logic                             serial_irq
);

  logic [7:0] mode_q;
  logic [7:0] shift_q;
  logic [7:0] slave_addr_q;
  logic       rel_trig_q;
  logic       cmd_trig_q;
  logic       rel_det_q;
  logic       cmd_det_q;
  logic       out_latch_q;
  logic [3:0] bit_cnt_q;
  logic       busy_q;
  logic       addr_phase_q;
  logic       irq_q;
  logic [31:0] prdata_q;
  logic       pslverr_q;
  logic       pready_q;
  serial_chan_pkg::pin_drive_t sclk_q;
  serial_chan_pkg::pin_drive_t pin_a_q;
  serial_chan_pkg::pin_drive_t pin_b_q;

  // one serial step: the received bit enters at the end opposite the outgoing bit
  function automatic logic [7:0] shift_next(input logic       lsb,
                                            input logic [7:0] cur,
                                            input logic       bit_in);
    return lsb ? {bit_in, cur[7:1]} : {cur[6:0], bit_in};
  endfunction

  wire chan_enable    = mode_q[serial_chan_pkg::MODE_ENABLE_BIT];
  wire wake_addr_only = mode_q[serial_chan_pkg::MODE_WAKE_BIT];
  wire mode_sel_hi    = mode_q[serial_chan_pkg::MODE_HI_BIT];
  wire mode_sel_mid   = mode_q[serial_chan_pkg::MODE_MID_BIT];
  wire mode_sel_lo    = mode_q[serial_chan_pkg::MODE_LO_BIT];

  serial_chan_pkg::chan_mode_t mode;
  assign mode = !mode_sel_hi ? serial_chan_pkg::MODE_THREE_WIRE :   // RL1
                 mode_sel_mid ? serial_chan_pkg::MODE_TWO_WIRE :     // RL3
                                serial_chan_pkg::MODE_ADDR_BUS;      // RL2
  // bus and two-wire modes always send the top bit first
  wire lsb_first = (mode == serial_chan_pkg::MODE_THREE_WIRE) & mode_sel_lo; // RL1

  // sampled pins
  // two flops give the level; the third stage is only there to find edges
  logic sclk_lvl, sclk_rise, sclk_fall;
  logic a_lvl, a_rise, a_fall;
  logic b_lvl, b_rise, b_fall;
  edge_sync u_sync_clk (.pclk(pclk), .presetn(presetn), .async_in(sclk_in),
                        .level(sclk_lvl), .rise(sclk_rise), .fall(sclk_fall));
  edge_sync u_sync_a (.pclk(pclk), .presetn(presetn), .async_in(pin_a_in),
                      .level(a_lvl), .rise(a_rise), .fall(a_fall));
  edge_sync u_sync_b (.pclk(pclk), .presetn(presetn), .async_in(pin_b_in),
                      .level(b_lvl), .rise(b_rise), .fall(b_fall));

  // bus line: lo bit 0 uses pin b, 1 uses pin a (the other one is freed)
  wire bus_on_a  = mode_sel_lo;                                      // RL2
  wire bus_lvl   = bus_on_a ? a_lvl : b_lvl;
  wire bus_rise  = bus_on_a ? a_rise : b_rise;
  wire bus_fall  = bus_on_a ? a_fall : b_fall;
  // three-wire input always on pin a; in transmit-only use it is just a port
  wire rx_bit    = (mode == serial_chan_pkg::MODE_THREE_WIRE) ? a_lvl : bus_lvl; // RL5
  wire [7:0] shift_nx = shift_next(lsb_first, shift_q, rx_bit);

  // bus release: data rises while clock high; command: data falls while clock high
  wire in_bus_mode  = chan_enable & (mode == serial_chan_pkg::MODE_ADDR_BUS);
  wire bus_watch    = in_bus_mode & sclk_lvl & ~busy_q;
  wire rel_seen     = bus_watch & bus_rise;                          // RL14
  wire cmd_seen     = bus_watch & bus_fall;                          // RL17

  // apb decode
  wire acc        = psel & penable;
  wire wr         = acc & pwrite;
  wire sel_mode   = (paddr == serial_chan_pkg::ADDR_MODE);
  wire sel_shift  = (paddr == serial_chan_pkg::ADDR_SHIFT);
  wire sel_sva    = (paddr == serial_chan_pkg::ADDR_SLAVE_ADDR);
  wire sel_bc     = (paddr == serial_chan_pkg::ADDR_BUS_CTRL);
  wire sel_stat   = (paddr == serial_chan_pkg::ADDR_STATUS);
  wire mapped     = sel_mode | sel_shift | sel_sva | sel_bc | sel_stat;
  wire start_xfer = wr & sel_shift & chan_enable;                    // RL18
  wire rel_trig_wr = wr & sel_bc & pwdata[serial_chan_pkg::BC_REL_TRIG_BIT]; // RL12
  wire cmd_trig_wr = wr & sel_bc & pwdata[serial_chan_pkg::BC_CMD_TRIG_BIT]; // RL12

  // combinational, so the flag follows every write to either register at once
  wire addr_match = chan_enable & (slave_addr_q == shift_q);         // RL9 RL10
  wire [7:0] mode_rd = {mode_q[7], addr_match, mode_q[5:0]};         // RL9
  wire [7:0] bc_rd   = {4'h0, cmd_det_q, rel_det_q, 2'b00};          // RL20
  wire [7:0] stat_rd = {3'h0, busy_q, bit_cnt_q};

  // unmapped addresses read back zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (sel_mode)  rd_mux = mode_rd;
    if (sel_shift) rd_mux = shift_q;
    if (sel_sva)   rd_mux = slave_addr_q;
    if (sel_bc)    rd_mux = bc_rd;
    if (sel_stat)  rd_mux = stat_rd;
  end

  // zero-wait answer: pready held high, read data registered on setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= {24'h00_0000, rd_mux};
      pslverr_q <= psel & ~penable & ~mapped;
    end
  end

  // no wait states: ready rises on the first edge after reset and stays high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pready_q <= 1'b0;
    else
      pready_q <= 1'b1;
  end

  // configuration registers; match flag is never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q       <= serial_chan_pkg::MODE_RESET;
      slave_addr_q <= 8'h00;
    end else begin
      if (wr & sel_mode)
        mode_q <= {pwdata[7], 1'b0, pwdata[5:0]};                    // RL9
      if (wr & sel_sva)
        slave_addr_q <= pwdata[7:0];
    end
  end

  // shift engine: bits sampled on serial clock rise, driven on fall
  // a transfer ends on the eighth rise; the counter then rests at the full count
  wire last_bit = (bit_cnt_q == (serial_chan_pkg::BIT_COUNT_LAST - 4'h1));
  wire done     = busy_q & sclk_rise & last_bit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q   <= serial_chan_pkg::SHIFT_RESET;
      bit_cnt_q <= 4'h0;
      busy_q    <= 1'b0;
    end else if (!chan_enable) begin                                 // RL11
      // stopped: the shift register is an ordinary data register
      busy_q    <= 1'b0;
      bit_cnt_q <= 4'h0;
      if (wr & sel_shift)
        shift_q <= pwdata[7:0];
    end else if (start_xfer) begin                                   // RL18
      shift_q   <= pwdata[7:0];
      bit_cnt_q <= 4'h0;
      busy_q    <= 1'b1;
    end else if (busy_q & sclk_rise) begin
      shift_q   <= shift_nx;                                         // RL1
      bit_cnt_q <= bit_cnt_q + 4'h1;
      busy_q    <= ~last_bit;
    end
  end

  // first transfer after a release followed by a command is an address reception
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      addr_phase_q <= 1'b0;
    else if (!chan_enable)
      addr_phase_q <= 1'b0;
    else if (start_xfer)
      addr_phase_q <= rel_det_q & cmd_det_q;                         // RL7
    else if (done)
      addr_phase_q <= 1'b0;
  end

  wire addr_done  = done & addr_phase_q;
  wire addr_equal = (slave_addr_q == shift_nx);

  // detection flags: a new detection wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_det_q <= 1'b0;                                             // RL12 RL15
      cmd_det_q <= 1'b0;
    end else if (!chan_enable) begin
      rel_det_q <= 1'b0;                                             // RL15
      cmd_det_q <= 1'b0;                                             // RL17
    end else begin
      if (rel_seen)
        rel_det_q <= 1'b1;                                           // RL14
      else if (start_xfer | (addr_done & ~addr_equal))
        rel_det_q <= 1'b0;                                           // RL15 RL16
      if (cmd_seen)
        cmd_det_q <= 1'b1;                                           // RL17
      else if (start_xfer | rel_seen)
        cmd_det_q <= 1'b0;                                           // RL17
    end
  end

  // while enabled, triggers act on the latch in the cycle after the write, then self-clear; while disabled only release acts, at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_trig_q  <= 1'b0;
      cmd_trig_q  <= 1'b0;
      out_latch_q <= 1'b1;
    end else if (!chan_enable) begin
      rel_trig_q  <= 1'b0;                                           // RL13
      cmd_trig_q  <= 1'b0;                                           // RL13
      if (rel_trig_wr)
        out_latch_q <= 1'b1;
    end else begin
      // the latch also carries the outgoing bit: a trigger mid-transfer corrupts it
      rel_trig_q <= rel_trig_wr;                                     // RL12
      cmd_trig_q <= cmd_trig_wr;
      if (rel_trig_q)
        out_latch_q <= 1'b1;                                         // RL13
      else if (cmd_trig_q)
        out_latch_q <= 1'b0;                                         // RL13
      else if (start_xfer)
        out_latch_q <= lsb_first ? pwdata[0] : pwdata[7];
      else if (busy_q & sclk_fall)
        out_latch_q <= lsb_first ? shift_q[0] : shift_q[7];
      else if (done & (mode != serial_chan_pkg::MODE_THREE_WIRE))
        out_latch_q <= 1'b1;
    end
  end

  // interrupt: one pclk pulse per completed transfer, or per address match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_q <= 1'b0;
    else if (wake_addr_only & (mode == serial_chan_pkg::MODE_ADDR_BUS))
      irq_q <= addr_done & addr_equal;                               // RL7
    else
      irq_q <= done;                                                 // RL6
  end

  // pin roles; open-drain drives only low, freed pins left to port logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q  <= '{out: 1'b1, oe: 1'b0};
      pin_a_q <= '{out: 1'b1, oe: 1'b0};
      pin_b_q <= '{out: 1'b1, oe: 1'b0};
    end else begin
      sclk_q  <= '{out: 1'b1, oe: 1'b0};
      pin_a_q <= '{out: 1'b1, oe: 1'b0};
      pin_b_q <= '{out: 1'b1, oe: 1'b0};
      if (chan_enable) begin                                         // RL11
        case (mode)
          serial_chan_pkg::MODE_THREE_WIRE:
            pin_b_q <= '{out: out_latch_q, oe: 1'b1};                // RL1
          serial_chan_pkg::MODE_ADDR_BUS, serial_chan_pkg::MODE_TWO_WIRE: begin
            if (bus_on_a)
              pin_a_q <= '{out: 1'b0, oe: ~out_latch_q};             // RL2
            else
              pin_b_q <= '{out: 1'b0, oe: ~out_latch_q};             // RL2
          end
          default: ;
        endcase
      end
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign sclk_drv   = sclk_q;
  assign pin_a_drv  = pin_a_q;
  assign pin_b_drv  = pin_b_q;
  assign serial_irq = irq_q;
endmodule // serial_channel

// ===== dv/serial_channel_chk.sv
`timescale 1ns/1ns
module serial_channel_chk (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [17:0]                 paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        sclk_in,
  input wire serial_chan_pkg::pin_drive_t sclk_drv,
  input wire logic                        pin_a_in,
  input wire serial_chan_pkg::pin_drive_t pin_a_drv,
  input wire logic                        pin_b_in,
  input wire serial_chan_pkg::pin_drive_t pin_b_drv,
  input wire logic                        serial_irq
);
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [1:0] off_q;
  logic [1:0] off_d;
  logic       rd_acc;
  logic       mapped;
  logic       quiet;
  assign rd_acc = psel && penable && !pwrite;
  assign mapped = paddr inside {serial_chan_pkg::ADDR_MODE, serial_chan_pkg::ADDR_SHIFT,
    serial_chan_pkg::ADDR_SLAVE_ADDR, serial_chan_pkg::ADDR_STATUS,
    serial_chan_pkg::ADDR_BUS_CTRL};
  assign mode_d = (psel && penable && pwrite && pready && paddr == serial_chan_pkg::ADDR_MODE)
    ? pwdata[7:0] : mode_q;
  // quiet only after the enable has been low long enough for registered reads to settle
  assign off_d = mode_q[7] ? 2'h0 : ((off_q == 2'h3) ? 2'h3 : off_q + 2'h1);
  assign quiet = !mode_q[7] && (off_q == 2'h3);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= serial_chan_pkg::MODE_RESET;
      off_q  <= 2'h3;
    end else begin
      mode_q <= mode_d;
      off_q  <= off_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_unmapped_err:
    assert property (psel && penable && !mapped |-> pslverr) else $error("no error on unmapped");
  a_unmapped_zero:
    assert property (rd_acc && !mapped |-> prdata == 32'h0) else $error("unmapped read not 0");
  a_trig_read_zero:
    assert property (rd_acc && paddr == serial_chan_pkg::ADDR_BUS_CTRL |-> prdata[1:0] == 2'h0)
    else $error("trigger bits read back set");
  a_flags_cleared:
    assert property (rd_acc && quiet && paddr == serial_chan_pkg::ADDR_BUS_CTRL
      |-> prdata[3:2] == 2'h0) else $error("detect flags set while disabled");
  a_match_off:
    assert property (rd_acc && quiet && paddr == serial_chan_pkg::ADDR_MODE |-> !prdata[6])
    else $error("match flag set while disabled");
  a_irq_single:
    assert property (serial_irq |=> (!serial_irq) [*4]) else $error("irq longer than a pulse");
  a_irq_stopped:
    assert property (quiet |-> !serial_irq) else $error("irq while disabled");
  a_pin_a_od:
    assert property (pin_a_drv.oe |-> !pin_a_drv.out) else $error("pin a driven high");
  a_pin_b_od:
    assert property (mode_q[4] && $past(mode_q[4]) && pin_b_drv.oe |-> !pin_b_drv.out)
    else $error("bus line driven high");
endmodule // serial_channel_chk

// ===== dv/serial_channel_mode_and_bus_control_bench.sv
`timescale 1ns/1ns
module serial_channel_mode_and_bus_control_bench;
  logic                        pclk;
  logic                        presetn;
  logic                        psel;
  logic                        penable;
  logic                        pwrite;
  logic [17:0]                 paddr;
  logic [31:0]                 pwdata;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic                        serial_irq;
  logic                        pull_low;
  logic                        sclk;
  logic                        sdata;
  logic                        wire_a;
  logic                        wire_b;
  logic [31:0]                 r;
  logic [7:0]                  rx;
  logic                        got;
  int                          n_fail;
  int                          checks;
  serial_chan_pkg::pin_drive_t sclk_drv;
  serial_chan_pkg::pin_drive_t pin_a_drv;
  serial_chan_pkg::pin_drive_t pin_b_drv;
  assign wire_a = pin_a_drv.oe ? pin_a_drv.out : sdata;
  // bus line has a pull-up; the bench pulls it low in the far side's place
  assign wire_b = pin_b_drv.oe ? pin_b_drv.out : !pull_low;
  serial_channel u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk_in(sclk), .sclk_drv(sclk_drv), .pin_a_in(wire_a),
    .pin_a_drv(pin_a_drv), .pin_b_in(wire_b), .pin_b_drv(pin_b_drv), .serial_irq(serial_irq));
  serial_peer u_peer (.sclk(sclk), .sdata(sdata), .sdo(wire_b));
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    r = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
    if (n >= 20) begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] e);
    apb(1'h0, a, 32'h0);
    chk(r, {24'h0, e});
  endtask
  task automatic xfer(input logic [7:0] tx);
    got = 1'h0;
    fork
      u_peer.frame(tx, rx);
      for (int i = 0; i < 120 && !got; i++) begin
        @(posedge pclk);
        got = serial_irq;
      end
    join
    @(posedge pclk);
  endtask
  task automatic line(input logic lo);
    pull_low <= lo;
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    presetn  = 1'h0;
    psel     = 1'h0;
    penable  = 1'h0;
    pwrite   = 1'h0;
    paddr    = 18'h0;
    pwdata   = 32'h0;
    pull_low = 1'h0;
    n_fail   = 0;
    checks   = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(serial_chan_pkg::ADDR_MODE, 8'h00);
    rd(serial_chan_pkg::ADDR_BUS_CTRL, 8'h00);
    rd(18'h00010, 8'h00);
    apb(1'h1, serial_chan_pkg::ADDR_SLAVE_ADDR, 32'hff);
    apb(1'h1, serial_chan_pkg::ADDR_MODE, 32'h40);
    rd(serial_chan_pkg::ADDR_MODE, 8'h00);
    apb(1'h1, serial_chan_pkg::ADDR_MODE, 32'h80);
    rd(serial_chan_pkg::ADDR_MODE, 8'hc0);
    apb(1'h1, serial_chan_pkg::ADDR_SLAVE_ADDR, 32'h12);
    rd(serial_chan_pkg::ADDR_MODE, 8'h80);
    $display("test registers and match flag done");
    apb(1'h1, serial_chan_pkg::ADDR_SHIFT, 32'ha5);
    xfer(8'h5a);
    chk(got, 1'h1);
    chk(rx, 8'ha5);
    rd(serial_chan_pkg::ADDR_SHIFT, 8'h5a);
    apb(1'h1, serial_chan_pkg::ADDR_MODE, 32'h04);
    apb(1'h1, serial_chan_pkg::ADDR_MODE, 32'h84);
    apb(1'h1, serial_chan_pkg::ADDR_SHIFT, 32'h01);
    xfer(8'h0f);
    chk(got, 1'h1);
    chk(rx, 8'h80);
    rd(serial_chan_pkg::ADDR_SHIFT, 8'hf0);
    apb(1'h1, serial_chan_pkg::ADDR_MODE, 32'h00);
    apb(1'h1, serial_chan_pkg::ADDR_SHIFT, 32'h33);
    xfer(8'h00);
    chk(got, 1'h0);
    rd(serial_chan_pkg::ADDR_SHIFT, 8'h33);
    $display("test three-wire transfers done");
    apb(1'h1, serial_chan_pkg::ADDR_MODE, 32'h10);
    apb(1'h1, serial_chan_pkg::ADDR_MODE, 32'h90);
    apb(1'h1, serial_chan_pkg::ADDR_BUS_CTRL, 32'h2);
    line(1'h0);
    chk({pin_b_drv.oe, pin_b_drv.out}, 2'h2);
    rd(serial_chan_pkg::ADDR_BUS_CTRL, 8'h08);
    apb(1'h1, serial_chan_pkg::ADDR_BUS_CTRL, 32'h1);
    line(1'h0);
    chk(pin_b_drv.oe, 1'h0);
    line(1'h1);
    line(1'h0);
    rd(serial_chan_pkg::ADDR_BUS_CTRL, 8'h04);
    line(1'h1);
    rd(serial_chan_pkg::ADDR_BUS_CTRL, 8'h0c);
    apb(1'h1, serial_chan_pkg::ADDR_MODE, 32'h10);
    rd(serial_chan_pkg::ADDR_BUS_CTRL, 8'h00);
    line(1'h0);
    apb(1'h1, serial_chan_pkg::ADDR_MODE, 32'h1c);
    apb(1'h1, serial_chan_pkg::ADDR_MODE, 32'h9c);
    apb(1'h1, serial_chan_pkg::ADDR_BUS_CTRL, 32'h2);
    line(1'h0);
    chk({pin_a_drv.oe, pin_a_drv.out}, 2'h2);
    chk(pin_b_drv.oe, 1'h0);
    apb(1'h1, serial_chan_pkg::ADDR_BUS_CTRL, 32'h1);
    line(1'h0);
    chk(pin_a_drv.oe, 1'h0);
    $display("test bus control done");
    tally_and_finish;
  end
endmodule // serial_channel_mode_and_bus_control_bench
bind serial_channel serial_channel_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sclk_in(sclk_in), .sclk_drv(sclk_drv),
  .pin_a_in(pin_a_in), .pin_a_drv(pin_a_drv), .pin_b_in(pin_b_in), .pin_b_drv(pin_b_drv),
  .serial_irq(serial_irq));

// ===== dv/serial_peer.sv
`timescale 1ns/1ns
// far-side clocked serial device: clock idles high between frames, MSB first
module serial_peer (
  output logic      sclk,
  output logic      sdata,
  input  wire logic sdo
);
  initial begin
    sclk  = 1'h1;
    sdata = 1'h1;
  end
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    // callers start right on a clock edge; step off it so no pin moves there
    #20;
    for (int i = 7; i >= 0; i--) begin
      sclk  = 1'h0;
      sdata = tx[i];
      #400;
      sclk  = 1'h1;
      rx[i] = sdo;
      #400;
    end
    // released data line shows no stale bit
    sdata = ~tx[0];
  endtask
endmodule // serial_peer
